// [hw/ets_defines.svh]
// Offsets, field positions, reset values and timing counts for the acquisition sequencer
`ifndef ETS_DEFINES_SVH
`define ETS_DEFINES_SVH
// Register word offsets on the plain register port
`define ETS_ADDR_CTRL 4'h0
`define ETS_ADDR_EXPOSE 4'h1
`define ETS_ADDR_COMP 4'h2
`define ETS_ADDR_GEOM 4'h3
`define ETS_ADDR_STATUS 4'h4
// Control field positions
`define ETS_CTRL_START_BIT 0
`define ETS_CTRL_STOP_BIT 1
`define ETS_CTRL_EDGE_BIT 2
`define ETS_CTRL_MODE_LSB 4
`define ETS_CTRL_SHUT_LSB 8
`define ETS_CTRL_RATE_LSB 12
`define ETS_CTRL_VARIANT_BIT 16
// Reset values
`define ETS_EXPOSE_RST 32'h0000_03e8
`define ETS_COMP_RST 32'h0000_0064
`define ETS_GEOM_RST 32'h0004_0006
// Clock rate and conversion rates in kHz
`define ETS_CLK_KHZ 100000
`define ETS_RATE_50K_KHZ 50
`define ETS_RATE_100K_KHZ 100
`define ETS_RATE_250K_KHZ 250
`define ETS_RATE_500K_KHZ 500
`define ETS_RATE_1M_KHZ 1000
`define ETS_RATE_2M_KHZ 2000
// Cycles for one row shift
`define ETS_ROW_SHIFT_CYC 16'h0020
// Full-scale code and baseline offset added before conversion
`define ETS_FULL_SCALE 16'hffff
`define ETS_BASELINE 16'h0040
`endif

// [hw/ets_pkg.sv]
// Types shared by the acquisition sequencer
package ets_pkg;
  // Timing mode selection
  typedef enum logic [1:0] {
    ETS_MODE_FREE = 2'h0,
    ETS_MODE_SYNC = 2'h1,
    ETS_MODE_SYNC_CC = 2'h2
  } ets_mode_type;
  // Shutter option selection
  typedef enum logic [1:0] {
    ETS_SHUT_NORMAL = 2'h0,
    ETS_SHUT_OPEN_EARLY = 2'h1,
    ETS_SHUT_HELD_OPEN = 2'h2,
    ETS_SHUT_HELD_CLOSED = 2'h3
  } ets_shut_type;
  // Settings latched at acquisition start
  typedef struct packed {
    ets_mode_type mode;
    ets_shut_type shut;
    logic [2:0] rate;
    logic edge_rise;
    logic multi_rate;
  } ets_cfg_type;
  // Converted sample out to the data path
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } ets_sample_type;
endpackage : ets_pkg

// [hw/ets_pixel_pacer.sv]
// Conversion pacer: one strobe per pixel at the selected conversion rate
`timescale 1ns/1ns
`default_nettype none
`include "ets_defines.svh"
module ets_pixel_pacer
  import ets_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] rate,
  input wire logic multi_rate,
  output logic tick
);
  // Divider count per rate; single-converter variant only honours codes 0 and 1
  function automatic logic [11:0] div_of(input logic [2:0] r, input logic m);
    logic [2:0] sel;
    sel = m ? r : {2'h0, r[0]};
    unique case (sel)
      3'h0: div_of = 12'(`ETS_CLK_KHZ / `ETS_RATE_100K_KHZ - 1);
      3'h1: div_of = 12'(`ETS_CLK_KHZ / `ETS_RATE_1M_KHZ - 1);
      3'h2: div_of = 12'(`ETS_CLK_KHZ / `ETS_RATE_50K_KHZ - 1);
      3'h3: div_of = 12'(`ETS_CLK_KHZ / `ETS_RATE_250K_KHZ - 1);
      3'h4: div_of = 12'(`ETS_CLK_KHZ / `ETS_RATE_500K_KHZ - 1);
      default: div_of = 12'(`ETS_CLK_KHZ / `ETS_RATE_2M_KHZ - 1);
    endcase
  endfunction : div_of
  logic [11:0] cnt_ff; // Cycles left in this pixel
  logic [11:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  // Next-count logic
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (!run) begin
      nxt_cnt = div_of(rate, multi_rate);
    end else if (cnt_ff == 12'h000) begin
      nxt_cnt = div_of(rate, multi_rate);
      nxt_tick = 1'b1;
    end else begin
      nxt_cnt = cnt_ff - 12'h001;
    end
  end
  // Registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 12'h000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
  assign tick = tick_ff;
endmodule : ets_pixel_pacer
`default_nettype wire

// [hw/ets_sequencer.sv]
// Acquisition sequencer: shutter, exposure, compensation, cleans and readout
`timescale 1ns/1ns
`default_nettype none
`include "ets_defines.svh"
module ets_sequencer
  import ets_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ext_sync,
  input wire logic [15:0] pix_analog,
  output logic shutter_open,
  output logic not_scan,
  output logic cleaning,
  output logic [15:0] sample_code,
  output logic sample_valid
);
  // One-hot sequencer states
  typedef enum logic [6:0] {
    ETS_ST_IDLE = 7'h01,
    ETS_ST_WAIT = 7'h02,
    ETS_ST_CLEAN_END = 7'h04,
    ETS_ST_EXPOSE = 7'h08,
    ETS_ST_COMP = 7'h10,
    ETS_ST_READ = 7'h20,
    ETS_ST_STOPPING = 7'h40
  } ets_state_type;

  // Settings and state
  ets_cfg_type cfg_ff, nxt_cfg; // Settings; latched copy steers the run
  logic [31:0] expose_ff, nxt_expose; // Exposure in cycles
  logic [31:0] comp_ff, nxt_comp; // Shutter compensation in cycles
  logic [31:0] geom_ff, nxt_geom; // [31:16] rows, [15:0] samples per row
  ets_state_type st_ff, nxt_st;
  logic [31:0] tcnt_ff, nxt_tcnt; // Interval counter
  logic [15:0] pix_ff, nxt_pix; // Samples left in row
  logic [15:0] row_ff, nxt_row; // Rows left
  logic [15:0] shift_ff, nxt_shift; // Clean row shift counter
  logic pend_ff, nxt_pend; // Sync edge held during a row shift
  logic stop_ff, nxt_stop; // Stop requested
  logic [1:0] sync_sy_ff; // Pin synchroniser
  logic sync_d_ff; // Previous synchronised level
  logic shut_ff, nxt_shut;
  logic nscan_ff, nxt_nscan;
  logic clean_ff, nxt_clean;
  logic [31:0] rdata_ff, nxt_rdata;
  ets_sample_type smp_ff, nxt_smp;
  logic tick;
  logic edge_seen;
  logic cfg_legal;
  logic early;

  // Pin synchroniser; only the second stage is read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_sy_ff <= 2'h0;
      sync_d_ff <= 1'b0;
    end else begin
      sync_sy_ff <= {sync_sy_ff[0], ext_sync};
      sync_d_ff <= sync_sy_ff[1];
    end
  end
  // Selected trigger edge
  assign edge_seen = cfg_ff.edge_rise ? (sync_sy_ff[1] & ~sync_d_ff)
                                      : (~sync_sy_ff[1] & sync_d_ff);

  // legal mode check on the written settings
  // Judged on the raw write data, since the settings path remaps mode 3 to free run
  // Early open in free run stays legal; it is turned into a normal shutter below
  assign cfg_legal = (reg_wdata[`ETS_CTRL_MODE_LSB +: 2] != 2'h3);
  // early open only meaningful with sync modes
  assign early = (cfg_ff.shut == ETS_SHUT_OPEN_EARLY) && (cfg_ff.mode != ETS_MODE_FREE);

  // Conversion pacer runs only during readout
  ets_pixel_pacer u_pacer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(st_ff == ETS_ST_READ),
    .rate(cfg_ff.rate),
    .multi_rate(cfg_ff.multi_rate),
    .tick(tick)
  );

  // Shutter level for an active phase, honouring held settings
  function automatic logic shut_level(input ets_shut_type s, input logic want);
    unique case (s)
      ETS_SHUT_HELD_OPEN: shut_level = 1'b1;
      ETS_SHUT_HELD_CLOSED: shut_level = 1'b0;
      default: shut_level = want;
    endcase
  endfunction : shut_level

  // Register port, settings and sequencing
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_expose = expose_ff;
    nxt_comp = comp_ff;
    nxt_geom = geom_ff;
    nxt_st = st_ff;
    nxt_tcnt = tcnt_ff;
    nxt_pix = pix_ff;
    nxt_row = row_ff;
    nxt_shift = shift_ff;
    nxt_pend = pend_ff;
    nxt_stop = stop_ff;
    nxt_rdata = 32'h0000_0000;
    nxt_smp = '{valid: 1'b0, code: smp_ff.code};
    // Reads answer the cycle after the strobe; unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        `ETS_ADDR_CTRL: nxt_rdata = {15'h0000, cfg_ff.multi_rate, 1'b0, cfg_ff.rate,
                                     2'h0, cfg_ff.shut, 2'h0, cfg_ff.mode,
                                     1'b0, cfg_ff.edge_rise, 2'h0};
        `ETS_ADDR_EXPOSE: nxt_rdata = expose_ff;
        `ETS_ADDR_COMP: nxt_rdata = comp_ff;
        `ETS_ADDR_GEOM: nxt_rdata = geom_ff;
        `ETS_ADDR_STATUS: nxt_rdata = {25'h0000000, st_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr && st_ff == ETS_ST_IDLE) begin
      unique case (reg_addr)
        `ETS_ADDR_CTRL: begin
          nxt_cfg.mode = ets_mode_type'(reg_wdata[`ETS_CTRL_MODE_LSB +: 2]);
          nxt_cfg.shut = ets_shut_type'(reg_wdata[`ETS_CTRL_SHUT_LSB +: 2]);
          nxt_cfg.rate = reg_wdata[`ETS_CTRL_RATE_LSB +: 3];
          nxt_cfg.edge_rise = reg_wdata[`ETS_CTRL_EDGE_BIT];
          nxt_cfg.multi_rate = reg_wdata[`ETS_CTRL_VARIANT_BIT];
          // early open in free run becomes normal
          if (nxt_cfg.mode == ETS_MODE_FREE && nxt_cfg.shut == ETS_SHUT_OPEN_EARLY) begin
            nxt_cfg.shut = ETS_SHUT_NORMAL;
          end
          if (nxt_cfg.mode == 2'h3) begin
            nxt_cfg.mode = ETS_MODE_FREE;
          end
          if (reg_wdata[`ETS_CTRL_START_BIT] && cfg_legal) begin
            nxt_st = (nxt_cfg.mode == ETS_MODE_FREE) ? ETS_ST_EXPOSE : ETS_ST_WAIT;
            nxt_tcnt = expose_ff;
            nxt_stop = 1'b0;
            nxt_pend = 1'b0;
            nxt_shift = `ETS_ROW_SHIFT_CYC;
          end
        end
        `ETS_ADDR_EXPOSE: nxt_expose = reg_wdata;
        `ETS_ADDR_COMP: nxt_comp = reg_wdata;
        `ETS_ADDR_GEOM: nxt_geom = reg_wdata;
        default: ;
      endcase
    end else if (reg_wr && reg_addr == `ETS_ADDR_CTRL && reg_wdata[`ETS_CTRL_STOP_BIT]) begin
      nxt_stop = 1'b1; // Finish the current frame, then idle
    end
    unique case (st_ff)
      ETS_ST_IDLE: ;
      ETS_ST_WAIT: begin
        if (cfg_ff.mode == ETS_MODE_SYNC_CC) begin
          // row shift completes before frame starts
          nxt_shift = (shift_ff == 16'h0000) ? `ETS_ROW_SHIFT_CYC : shift_ff - 16'h0001;
          if (edge_seen) nxt_pend = 1'b1;
          if ((edge_seen || pend_ff) && shift_ff == 16'h0000) begin
            nxt_st = ETS_ST_EXPOSE;
            nxt_pend = 1'b0;
          end
        end else if (edge_seen) begin
          nxt_st = ETS_ST_EXPOSE;
        end
        nxt_tcnt = expose_ff;
      end
      ETS_ST_EXPOSE: begin
        nxt_tcnt = tcnt_ff - 32'h0000_0001;
        if (tcnt_ff <= 32'h0000_0001) begin
          nxt_st = ETS_ST_COMP;
          nxt_tcnt = (cfg_ff.shut[1]) ? 32'h0000_0000 : comp_ff;
        end
      end
      ETS_ST_COMP: begin
        nxt_tcnt = tcnt_ff - 32'h0000_0001;
        if (tcnt_ff <= 32'h0000_0001) begin
          nxt_st = ETS_ST_READ;
          nxt_row = geom_ff[31:16];
          nxt_pix = geom_ff[15:0];
        end
      end
      ETS_ST_READ: begin
        if (tick) begin
          nxt_smp.valid = 1'b1;
          nxt_smp.code = (pix_analog > (`ETS_FULL_SCALE - `ETS_BASELINE))
                         ? `ETS_FULL_SCALE : pix_analog + `ETS_BASELINE;
          if (pix_ff <= 16'h0001) begin
            nxt_pix = geom_ff[15:0];
            nxt_row = row_ff - 16'h0001;
            if (row_ff <= 16'h0001) begin
              nxt_st = stop_ff ? ETS_ST_STOPPING
                     : (cfg_ff.mode == ETS_MODE_FREE) ? ETS_ST_EXPOSE : ETS_ST_WAIT;
              nxt_tcnt = expose_ff;
              nxt_shift = `ETS_ROW_SHIFT_CYC;
            end
          end else begin
            nxt_pix = pix_ff - 16'h0001;
          end
        end
      end
      ETS_ST_STOPPING: nxt_st = ETS_ST_IDLE;
      default: nxt_st = ETS_ST_IDLE;
    endcase
  end

  // Output levels, computed from the next state so outputs are registered
  always_comb begin
    nxt_nscan = (nxt_st != ETS_ST_READ);
    // Next settings, so the start cycle already shows the new mode and option
    nxt_clean = (nxt_st == ETS_ST_WAIT) && (nxt_cfg.mode == ETS_MODE_SYNC_CC);
    // early open while waiting for sync
    nxt_shut = shut_level(nxt_cfg.shut, (nxt_st == ETS_ST_EXPOSE) ||
                          ((nxt_st == ETS_ST_WAIT) && (nxt_cfg.shut == ETS_SHUT_OPEN_EARLY)
                           && (nxt_cfg.mode != ETS_MODE_FREE)));
    if (nxt_st == ETS_ST_IDLE && !nxt_cfg.shut[1]) nxt_shut = 1'b0;
  end

  // All sequencer registers except the pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '{mode: ETS_MODE_FREE, shut: ETS_SHUT_NORMAL, rate: 3'h0,
                  edge_rise: 1'b0, multi_rate: 1'b0};
      expose_ff <= `ETS_EXPOSE_RST;
      comp_ff <= `ETS_COMP_RST;
      geom_ff <= `ETS_GEOM_RST;
      st_ff <= ETS_ST_IDLE;
      tcnt_ff <= 32'h0000_0000;
      pix_ff <= 16'h0000;
      row_ff <= 16'h0000;
      shift_ff <= 16'h0000;
      pend_ff <= 1'b0;
      stop_ff <= 1'b0;
      shut_ff <= 1'b0;
      nscan_ff <= 1'b1;
      clean_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      smp_ff <= '{valid: 1'b0, code: 16'h0000};
    end else begin
      cfg_ff <= nxt_cfg;
      expose_ff <= nxt_expose;
      comp_ff <= nxt_comp;
      geom_ff <= nxt_geom;
      st_ff <= nxt_st;
      tcnt_ff <= nxt_tcnt;
      pix_ff <= nxt_pix;
      row_ff <= nxt_row;
      shift_ff <= nxt_shift;
      pend_ff <= nxt_pend;
      stop_ff <= nxt_stop;
      shut_ff <= nxt_shut;
      nscan_ff <= nxt_nscan;
      clean_ff <= nxt_clean;
      rdata_ff <= nxt_rdata;
      smp_ff <= nxt_smp;
    end
  end

  assign reg_rdata = rdata_ff;
  assign shutter_open = shut_ff;
  assign not_scan = nscan_ff;
  assign cleaning = clean_ff;
  assign sample_code = smp_ff.code;
  assign sample_valid = smp_ff.valid;

  // Checks
  AST_NSCAN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff == ETS_ST_READ) |-> !not_scan) else $error("not_scan high in readout");
  AST_SHUT_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff == ETS_ST_READ && !cfg_ff.shut[1]) |-> !shutter_open)
    else $error("shutter open during readout");
  AST_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff != ETS_ST_IDLE && cfg_ff.shut == ETS_SHUT_HELD_CLOSED) |-> !shutter_open)
    else $error("held-closed shutter moved");
  AST_FREE_EARLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_ff.mode == ETS_MODE_FREE) |-> (cfg_ff.shut != ETS_SHUT_OPEN_EARLY))
    else $error("early open kept in free run");
  AST_EARLY_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff == ETS_ST_WAIT && early) |-> shutter_open) else $error("early shutter closed");
  AST_SMP_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sample_valid |-> $past(st_ff) == ETS_ST_READ) else $error("sample outside readout");
  AST_BASELINE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sample_valid |-> sample_code >= `ETS_BASELINE) else $error("sample below baseline");
  AST_CC_ROW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_ff == ETS_ST_WAIT && nxt_st == ETS_ST_EXPOSE && cfg_ff.mode == ETS_MODE_SYNC_CC)
    |-> shift_ff == 16'h0000) else $error("clean stopped mid-row");
  AST_FREE_NOWAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cfg_ff.mode == ETS_MODE_FREE) |-> st_ff != ETS_ST_WAIT) else $error("free run waits");
  COV_FRAME: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == ETS_ST_COMP ##1 st_ff == ETS_ST_READ);
  COV_CC: cover property (@(posedge ref_clk) disable iff (!rst_n)
    cleaning && edge_seen);
  COV_EARLY: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff == ETS_ST_WAIT && early);
endmodule : ets_sequencer
`default_nettype wire

// [bench/ets_far_side.sv]
// Far-side model: external trigger source, shutter watcher and pixel source
`timescale 1ns/1ns
`default_nettype none
module ets_far_side (
  input wire logic ref_clk,
  input wire logic shutter_open,
  input wire logic sample_valid,
  input wire logic fire,
  input wire logic rise,
  output logic ext_sync,
  output logic [15:0] pix_analog,
  output int shutter_moves
);
  int hold_cnt; // Cycles left at the active level
  logic last_shut; // Shutter level seen at the previous edge
  // Start idle low and at a level that saturates the converter
  initial begin
    ext_sync = 1'b0;
    pix_analog = 16'hfff0;
    hold_cnt = 0;
    shutter_moves = 0;
    last_shut = 1'b0;
  end
  // Trigger pulse, pixel source and shutter motion count
  always @(posedge ref_clk) begin
    if (fire) begin
      hold_cnt = 8;
    end
    // Short pulse, so the pin is idle again long before readout ends
    if (hold_cnt > 0) begin
      hold_cnt--;
      ext_sync <= rise;
    end else begin
      ext_sync <= !rise;
    end
    // New level only after a conversion, so it is steady at the next one
    if (sample_valid === 1'b1) begin
      pix_analog <= ($urandom_range(0, 3) == 0) ? {8'hff, 8'($urandom)} : 16'($urandom);
    end
    if (shutter_open !== last_shut) begin
      shutter_moves++;
    end
    last_shut = shutter_open;
  end
endmodule : ets_far_side
`default_nettype wire

// [bench/exposure_timing_shutter_sequencer_test.sv]
// Self-checking testbench for the acquisition sequencer
`timescale 1ns/1ns
`default_nettype none
`include "ets_defines.svh"
module exposure_timing_shutter_sequencer_test
  import ets_pkg::*;
;
  logic ref_clk, rst_n, reg_wr, reg_rd, ext_sync, shutter_open, not_scan;
  logic cleaning, sample_valid, fire, rise, ns_q;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] pix_analog, sample_code;
  int moves, miscompares, tests_run, cyc, run, n_samp, t1, t_close;
  int exp_e, exp_c, exp_n, exp_p; // Expected open run, gap, count, period
  ets_sequencer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_sync(ext_sync), .pix_analog(pix_analog), .shutter_open(shutter_open),
    .not_scan(not_scan), .cleaning(cleaning), .sample_code(sample_code),
    .sample_valid(sample_valid));
  ets_far_side far_u (.ref_clk(ref_clk), .shutter_open(shutter_open),
    .sample_valid(sample_valid), .fire(fire), .rise(rise), .ext_sync(ext_sync),
    .pix_analog(pix_analog), .shutter_moves(moves));
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task conclude;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data are taken in the one cycle where they stand
  task automatic rd(logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    v = reg_rdata;
  endtask : rd
  function automatic logic [31:0] ctl(logic [1:0] m, logic [1:0] s, logic [2:0] r,
      logic mr, logic e, logic [1:0] go);
    return {15'h0, mr, 1'b0, r, 2'h0, s, 2'h0, m, 1'b0, e, go};
  endfunction : ctl
  // Converter period in clock cycles for a rate code
  function automatic int per(logic mr, logic [2:0] r);
    int k;
    if (!mr) k = r[0] ? `ETS_RATE_1M_KHZ : `ETS_RATE_100K_KHZ;
    else if (r == 3'h0) k = `ETS_RATE_100K_KHZ;
    else if (r == 3'h1) k = `ETS_RATE_1M_KHZ;
    else if (r == 3'h2) k = `ETS_RATE_50K_KHZ;
    else if (r == 3'h3) k = `ETS_RATE_250K_KHZ;
    else if (r == 3'h4) k = `ETS_RATE_500K_KHZ;
    else k = `ETS_RATE_2M_KHZ;
    return `ETS_CLK_KHZ / k;
  endfunction : per
  // Pixel plus baseline, clipped at full scale
  function automatic logic [15:0] exp_code(logic [15:0] p);
    logic [16:0] s;
    s = {1'b0, p} + {1'b0, `ETS_BASELINE};
    return s[16] ? `ETS_FULL_SCALE : s[15:0];
  endfunction : exp_code
  // Monitor: samples, exposure length, compensation gap, count per readout
  always @(posedge ref_clk) begin
    cyc++;
    if (sample_valid === 1'b1) begin
      check("sample", sample_code, exp_code(pix_analog));
      n_samp++;
      if (n_samp == 1) t1 = cyc;
      if (n_samp == 2) check("period", cyc - t1, exp_p);
    end
    if (shutter_open === 1'b1) begin
      run++;
    end else if (run > 0) begin
      if (exp_e > 0) check("open", run, exp_e);
      run = 0;
      t_close = cyc;
    end
    if (not_scan === 1'b0 && ns_q === 1'b1 && exp_c >= 0) check("comp", cyc - t_close, exp_c);
    if (not_scan === 1'b1 && ns_q === 1'b0) begin
      check("count", n_samp, exp_n);
      n_samp = 0;
    end
    ns_q = not_scan;
  end
  // One acquisition: settings, start, trigger if synced, stop in readout
  task automatic run_one(ets_mode_type m, ets_shut_type s, logic [2:0] r, logic mr,
      logic e, int rows, int spr);
    int big, lat, m0, i;
    big = 20 + $urandom_range(0, 40);
    exp_c = s[1] ? -1 : 5 + $urandom_range(0, 20);
    exp_e = (s == ETS_SHUT_NORMAL || m == ETS_MODE_FREE && !s[1]) ? big : 0;
    exp_n = rows * spr;
    exp_p = per(mr, r);
    rise <= e;
    wr(`ETS_ADDR_EXPOSE, big);
    wr(`ETS_ADDR_COMP, (exp_c < 0) ? 0 : exp_c);
    wr(`ETS_ADDR_GEOM, {16'(rows), 16'(spr)});
    wr(`ETS_ADDR_CTRL, ctl(m, s, r, mr, e, 2'h1));
    if (m == ETS_MODE_FREE) begin
      repeat (2) @(posedge ref_clk);
      check("free_open", shutter_open, s != ETS_SHUT_HELD_CLOSED);
      m0 = moves;
    end else begin
      repeat (20) @(posedge ref_clk);
      check("wait_shut", shutter_open, s == ETS_SHUT_OPEN_EARLY);
      check("cleans", cleaning, m == ETS_MODE_SYNC_CC);
      m0 = moves;
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      lat = 0;
      while (s == ETS_SHUT_NORMAL && shutter_open !== 1'b1 && lat < 100) begin
        @(posedge ref_clk);
        lat++;
      end
      // Cleans may hold the edge for one row shift
      check("latency", lat <= ((m == ETS_MODE_SYNC_CC) ? 44 : 10), 1'b1);
    end
    i = 0;
    while (not_scan !== 1'b0 && i < 40000) begin
      @(posedge ref_clk);
      i++;
    end
    wr(`ETS_ADDR_CTRL, ctl(m, s, r, mr, e, 2'h2));
    while (not_scan !== 1'b1 && i < 40000) begin
      @(posedge ref_clk);
      i++;
    end
    check("readout", i < 40000, 1'b1);
    if (s[1]) check("held", moves - m0, 0);
    for (i = 0; i < 100; i++) begin
      rd(`ETS_ADDR_STATUS, d);
      if (d === 32'h1) break;
    end
    check("idle", d, 32'h1);
  endtask : run_one
  // Main sequence
  initial begin
    void'($urandom(88480));
    rst_n = 1'b0;
    {reg_wr, reg_rd, fire, rise, ns_q} = 5'h3;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    {miscompares, tests_run, cyc, run, n_samp, t1, t_close} = '0;
    {exp_e, exp_n, exp_p} = '0;
    exp_c = -1;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`ETS_ADDR_EXPOSE, d);
    check("expose_rst", d, `ETS_EXPOSE_RST);
    rd(`ETS_ADDR_COMP, d);
    check("comp_rst", d, `ETS_COMP_RST);
    rd(`ETS_ADDR_GEOM, d);
    check("geom_rst", d, `ETS_GEOM_RST);
    rd(4'hf, d);
    check("unmapped", d, 32'h0);
    check("idle_levels", {shutter_open, not_scan}, 2'h1);
    // Mode 3 is not a legal timing mode and must not start
    wr(`ETS_ADDR_CTRL, ctl(2'h3, 2'h0, 3'h1, 1'b0, 1'b1, 2'h1));
    rd(`ETS_ADDR_STATUS, d);
    check("illegal", d, 32'h1);
    for (int i = 0; i < 8; i++) begin
      run_one((i < 4) ? ETS_MODE_FREE : (i < 6) ? ETS_MODE_SYNC : ETS_MODE_SYNC_CC,
        (i < 4) ? ets_shut_type'(i[1:0]) : ets_shut_type'({1'b0, i[0]}), 3'h1, 1'b0,
        i[1], 1 + $urandom_range(0, 1), 2 + $urandom_range(0, 2));
    end
    for (int i = 0; i < 8; i++) begin
      run_one(ETS_MODE_FREE, ETS_SHUT_NORMAL, (i < 2) ? 3'(i) : 3'(i - 2), i >= 2, 1'b1, 1, 2);
    end
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
endmodule : exposure_timing_shutter_sequencer_test
`default_nettype wire
